//--- rtl/dio_pkg.sv
/*
 * constants for the digital pin block: register offsets, field
 * positions, reset values.
 * assumes a 32-bit avalon-mm slave with byte addresses.
 */
package dio_pkg;
    localparam logic [7:0] OFS_FUNC  = 8'h00;
    localparam logic [7:0] OFS_DIR   = 8'h04;
    localparam logic [7:0] OFS_PIN   = 8'h08;
    localparam logic [7:0] OFS_SET   = 8'h0C;
    localparam logic [7:0] OFS_CLR   = 8'h10;
    localparam logic [7:0] OFS_GSEL  = 8'h14;
    localparam logic [7:0] OFS_GPOL  = 8'h18;
    localparam logic [7:0] OFS_GCTL  = 8'h1C;
    localparam logic [7:0] OFS_PSEL  = 8'h20;
    localparam logic [7:0] OFS_PCTL  = 8'h24;
    localparam logic [7:0] OFS_STAT  = 8'h28;
    localparam logic [7:0] OFS_MASK  = 8'h2C;
    localparam logic [7:0] OFS_WAKE  = 8'h30;
    localparam logic [7:0] OFS_PWR   = 8'h34;
    localparam logic [7:0] OFS_PAD0  = 8'h40;
    localparam logic [7:0] OFS_PAD1  = 8'h44;
    localparam logic [7:0] OFS_PAD2  = 8'h48;
    localparam int NUM_PP    = 4;
    localparam int SEL_W     = 5;
    localparam int PAD_W     = 4;
    localparam int PAD_PER_W = 8;
    // pad field bits
    localparam int PAD_DRV   = 0;
    localparam int PAD_PU    = 1;
    localparam int PAD_PD    = 2;
    localparam int PAD_OD    = 3;
    // pattern control fields
    localparam int PC_EN     = 0;
    localparam int PC_POL    = 4;
    localparam int PC_PAT    = 8;
    localparam int PC_MODE   = 12;
    // status bits
    localparam int ST_PP     = 0;
    localparam int ST_PAT    = 4;
    localparam int ST_GRP    = 5;
    localparam int ST_W      = 6;
    // control bits
    localparam int GC_AND    = 0;
    localparam int PW_HOLD   = 0;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] RST_FUNC = 32'hFFFF_FFFF;
endpackage : dio_pkg

//--- rtl/dio_top.sv
/*
 * digital pin block: pin controller with direction, sense and set,
 * pad settings, pattern and group interrupts, wake and output hold.
 * assumes a power controller that reports sleep, power-down and deep
 * power-down, and pad cells that take the pad settings as levels.
 */
module dio_top #(
    parameter int N_PIN = 22,
    parameter int N_TW  = 2
) (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_b_i,
    input  wire logic              ce_i,
    input  wire logic [7:0]        avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic [31:0]            avs_readdata_o,
    output logic                   avs_waitrequest_o,
    input  wire logic [N_PIN-1:0]  pin_i,
    output logic [N_PIN-1:0]       pin_o,
    output logic [N_PIN-1:0]       pin_oe_o,
    input  wire logic [N_PIN-1:0]  periph_out_i,
    input  wire logic [N_PIN-1:0]  periph_oe_i,
    output logic [N_PIN-1:0]       periph_in_o,
    output logic [N_PIN*4-1:0]     pad_cfg_o,
    output logic [N_TW-1:0]        tw_mode_o,
    input  wire logic              pwr_sleep_i,
    input  wire logic              pwr_pd_i,
    input  wire logic              pwr_dpd_i,
    output logic                   wake_sleep_o,
    output logic                   wake_pd_o,
    output logic                   reboot_req_o,
    output logic                   irq_o
);
    if (N_PIN < 1 || N_PIN > 24 || N_TW < 1 || N_TW > N_PIN) begin : g_bad
        $error("dio_top: unsupported pin counts");
    end

    localparam int NP = dio_pkg::NUM_PP;
    localparam int SW = dio_pkg::SEL_W;
    localparam int PW = dio_pkg::PAD_W;
    localparam int SB = dio_pkg::ST_W;

    typedef struct packed {
        logic [N_PIN-1:0]          s1;
        logic [N_PIN-1:0]          s2;
        logic [N_PIN-1:0]          s3;
        logic [N_PIN-1:0]          func;
        logic [N_PIN-1:0]          dir;
        logic [N_PIN-1:0]          dout;
        logic [N_PIN-1:0]          gsel;
        logic [N_PIN-1:0]          gpol;
        logic                      gand;
        logic [NP-1:0][SW-1:0]     psel;
        logic [15:0]               pctl;
        logic [SB-1:0]             stat;
        logic [SB-1:0]             mask;
        logic [N_PIN-1:0]          wake;
        logic                      hold_en;
        logic                      hold_act;
        logic                      dpd_seen;
        logic [N_PIN-1:0][PW-1:0]  pad;
        logic [N_PIN-1:0]          po;
        logic [N_PIN-1:0]          poe;
        logic                      ack;
        logic [31:0]               rdata;
        logic                      wk_pd;
        logic                      reboot;
    } dio_state_s;

    dio_state_s st_reg;
    dio_state_s st_next;

    ////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [31:0] dio_merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  be
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction : dio_merge

    function automatic logic [31:0] dio_ext(input logic [N_PIN-1:0] v);
        logic [31:0] r;
        r = 32'h0000_0000;
        r[N_PIN-1:0] = v;
        return r;
    endfunction : dio_ext

    function automatic logic dio_pick(
        input logic [N_PIN-1:0] v,
        input logic [SW-1:0]    idx
    );
        logic r;
        r = 1'b0;
        for (int k = 0; k < N_PIN; k++) begin
            if (idx == SW'(k)) begin
                r = v[k];
            end
        end
        return r;
    endfunction : dio_pick

    ////////////////////////////////////////////////////////////////////
    // pad field views

    logic [N_PIN-1:0] pad_od;
    logic [31:0]      pad_word [3];

    always_comb begin
        for (int k = 0; k < 3; k++) begin
            pad_word[k] = 32'h0000_0000;
        end
        for (int p = 0; p < N_PIN; p++) begin
            pad_od[p] = st_reg.pad[p][dio_pkg::PAD_OD];
            pad_word[p / dio_pkg::PAD_PER_W][(p % dio_pkg::PAD_PER_W)*PW
                +: PW] = st_reg.pad[p];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt conditions

    logic [NP-1:0]    pp_val;
    logic [NP-1:0]    pp_hit;
    logic             pat_hit;
    logic [N_PIN-1:0] g_term;
    logic             g_hit;
    logic [SB-1:0]    ev;
    logic             pin_act;

    always_comb begin
        for (int i = 0; i < NP; i++) begin
            pp_val[i] = dio_pick(st_reg.s2, st_reg.psel[i]);
            // level condition, polarity bit high means active high
            pp_hit[i] = st_reg.pctl[dio_pkg::PC_EN + i] &
                (pp_val[i] == st_reg.pctl[dio_pkg::PC_POL + i]);
        end
        // all enabled pins equal the pattern value
        pat_hit = (st_reg.pctl[dio_pkg::PC_EN +: NP] != 4'h0) &
            (((pp_val ^ st_reg.pctl[dio_pkg::PC_PAT +: NP]) &
              st_reg.pctl[dio_pkg::PC_EN +: NP]) == 4'h0);
        g_term = ~(st_reg.s2 ^ st_reg.gpol);
        if (st_reg.gand) begin
            g_hit = (st_reg.gsel != '0) &
                (&(g_term | ~st_reg.gsel));
        end else begin
            g_hit = |(g_term & st_reg.gsel);
        end
        ev = '0;
        if (st_reg.pctl[dio_pkg::PC_MODE]) begin
            ev[dio_pkg::ST_PAT] = pat_hit;
        end else begin
            ev[dio_pkg::ST_PP +: NP] = pp_hit;
        end
        ev[dio_pkg::ST_GRP] = g_hit;
        // change on a wake-enabled input pin in pin-controller mode
        pin_act = |((st_reg.s2 ^ st_reg.s3) & st_reg.wake &
            st_reg.func & ~st_reg.dir);
    end

    ////////////////////////////////////////////////////////////////////
    // register bus and state update

    logic        req;
    logic        done;
    logic [31:0] rd_mux;
    logic [31:0] wmerge;

    assign req  = avs_read_i | avs_write_i;
    assign done = req & st_reg.ack;

    always_comb begin
        case (avs_address_i)
            dio_pkg::OFS_FUNC: rd_mux = dio_ext(st_reg.func);
            dio_pkg::OFS_DIR:  rd_mux = dio_ext(st_reg.dir);
            dio_pkg::OFS_PIN:  rd_mux = dio_ext(st_reg.s2);
            dio_pkg::OFS_SET:  rd_mux = dio_ext(st_reg.dout);
            dio_pkg::OFS_CLR:  rd_mux = dio_ext(st_reg.dout);
            dio_pkg::OFS_GSEL: rd_mux = dio_ext(st_reg.gsel);
            dio_pkg::OFS_GPOL: rd_mux = dio_ext(st_reg.gpol);
            dio_pkg::OFS_GCTL: rd_mux = {31'h0000_0000, st_reg.gand};
            dio_pkg::OFS_PSEL: rd_mux = {12'h000, st_reg.psel};
            dio_pkg::OFS_PCTL: rd_mux = {16'h0000, st_reg.pctl};
            dio_pkg::OFS_STAT: rd_mux = {26'h000_0000, st_reg.stat};
            dio_pkg::OFS_MASK: rd_mux = {26'h000_0000, st_reg.mask};
            dio_pkg::OFS_WAKE: rd_mux = dio_ext(st_reg.wake);
            dio_pkg::OFS_PWR:  rd_mux = {30'h0000_0000,
                st_reg.hold_act, st_reg.hold_en};
            dio_pkg::OFS_PAD0: rd_mux = pad_word[0];
            dio_pkg::OFS_PAD1: rd_mux = pad_word[1];
            dio_pkg::OFS_PAD2: rd_mux = pad_word[2];
            default:           rd_mux = 32'h0000_0000;
        endcase
        wmerge = dio_merge(rd_mux, avs_writedata_i, avs_byteenable_i);
    end

    always_comb begin
        logic [31:0] padw;
        logic [N_PIN-1:0] mo;
        logic [N_PIN-1:0] moe;
        logic [31:0]      wout;
        logic [31:0]      wbe;
        padw = 32'h0000_0000;
        // byte lanes of a write, and the output word merged with them
        wbe  = dio_merge(32'h0000_0000, 32'hFFFF_FFFF, avs_byteenable_i);
        wout = dio_merge(dio_ext(st_reg.dout), avs_writedata_i,
            avs_byteenable_i);
        mo   = '0;
        moe  = '0;
        st_next = st_reg;
        // two-flop synchroniser, third stage for change detect
        st_next.s1 = pin_i;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        // one wait state: ack rises after the first cycle of a request
        st_next.ack = req & ~st_reg.ack;
        if (req & ~st_reg.ack) begin
            st_next.rdata = rd_mux;
        end
        if (done && avs_write_i) begin
            case (avs_address_i)
                dio_pkg::OFS_FUNC:
                    st_next.func = wmerge[N_PIN-1:0];
                dio_pkg::OFS_DIR:
                    st_next.dir = wmerge[N_PIN-1:0];
                dio_pkg::OFS_PIN:
                    st_next.dout = wout[N_PIN-1:0];
                dio_pkg::OFS_SET:
                    st_next.dout = st_reg.dout |
                        (avs_writedata_i[N_PIN-1:0] &
                         wbe[N_PIN-1:0]);
                dio_pkg::OFS_CLR:
                    st_next.dout = st_reg.dout &
                        ~(avs_writedata_i[N_PIN-1:0] &
                          wbe[N_PIN-1:0]);
                dio_pkg::OFS_GSEL:
                    st_next.gsel = wmerge[N_PIN-1:0];
                dio_pkg::OFS_GPOL:
                    st_next.gpol = wmerge[N_PIN-1:0];
                dio_pkg::OFS_GCTL:
                    st_next.gand = wmerge[dio_pkg::GC_AND];
                dio_pkg::OFS_PSEL:
                    st_next.psel = wmerge[NP*SW-1:0];
                dio_pkg::OFS_PCTL:
                    st_next.pctl = wmerge[15:0];
                dio_pkg::OFS_MASK:
                    st_next.mask = wmerge[SB-1:0];
                dio_pkg::OFS_WAKE:
                    st_next.wake = wmerge[N_PIN-1:0];
                dio_pkg::OFS_PWR:
                    st_next.hold_en = wmerge[dio_pkg::PW_HOLD];
                dio_pkg::OFS_PAD0,
                dio_pkg::OFS_PAD1,
                dio_pkg::OFS_PAD2: begin
                    padw = wmerge;
                    for (int p = 0; p < N_PIN; p++) begin
                        if (avs_address_i == dio_pkg::OFS_PAD0 +
                            8'((p / dio_pkg::PAD_PER_W) * 4)) begin
                            st_next.pad[p] = padw[(p %
                                dio_pkg::PAD_PER_W)*PW +: PW];
                        end
                    end
                end
                default: ;
            endcase
        end
        // two-wire cells have no pull-down
        for (int p = N_PIN - N_TW; p < N_PIN; p++) begin
            st_next.pad[p][dio_pkg::PAD_PD] = 1'b0;
        end
        // sticky status: a read clears only the bits it reported,
        // so an event after the snapshot is kept; a new event wins
        if (done && avs_read_i && avs_address_i == dio_pkg::OFS_STAT) begin
            st_next.stat = (st_reg.stat & ~st_reg.rdata[SB-1:0]) | ev;
        end else begin
            st_next.stat = st_reg.stat | ev;
        end
        // output drive, open-drain cells drive low only
        for (int p = 0; p < N_PIN; p++) begin
            if (st_reg.func[p]) begin
                mo[p]  = st_reg.dout[p] & ~pad_od[p];
                moe[p] = st_reg.dir[p] &
                    (~pad_od[p] | ~st_reg.dout[p]);
            end else begin
                mo[p]  = periph_out_i[p] & ~pad_od[p];
                moe[p] = periph_oe_i[p] &
                    (~pad_od[p] | ~periph_out_i[p]);
            end
        end
        // hold pads while power-down lasts when asked for
        st_next.hold_act = st_reg.hold_en & pwr_pd_i;
        if (!st_next.hold_act) begin
            st_next.po  = mo;
            st_next.poe = moe;
        end
        // wake from power-down and deep power-down
        st_next.wk_pd = pin_act & (pwr_pd_i | pwr_dpd_i);
        st_next.dpd_seen = st_reg.dpd_seen | pwr_dpd_i;
        st_next.reboot = 1'b0;
        if (st_reg.dpd_seen && pin_act) begin
            st_next.reboot   = 1'b1;
            st_next.dpd_seen = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg       <= '0;
            st_reg.func  <= dio_pkg::RST_FUNC[N_PIN-1:0];
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign avs_waitrequest_o = req & ~st_reg.ack;
    assign avs_readdata_o    = st_reg.rdata;
    assign pin_o             = st_reg.po;
    assign pin_oe_o          = st_reg.poe;
    assign periph_in_o       = st_reg.s2;
    assign pad_cfg_o         = st_reg.pad;
    assign tw_mode_o         = pad_od[N_PIN-1 -: N_TW];
    assign irq_o             = |(st_reg.stat & st_reg.mask);
    assign wake_sleep_o      = pwr_sleep_i &
        |(st_reg.stat[dio_pkg::ST_PAT:0] &
          st_reg.mask[dio_pkg::ST_PAT:0]);
    assign wake_pd_o         = st_reg.wk_pd;
    assign reboot_req_o      = st_reg.reboot;

endmodule : dio_top

//--- dv/dio_brd.sv
/*
 * board model: drives each pin from a board level unless the block
 * drives it.
 * assumes one driver per pin, no contention.
 */
module dio_brd (
    input  wire logic [21:0] lvl_i,
    input  wire logic [21:0] drv_i,
    input  wire logic [21:0] en_i,
    output logic      [21:0] pad_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // block drives where enabled, the board elsewhere
    assign pad_o = (en_i & drv_i) | (~en_i & lvl_i);
endmodule : dio_brd

//--- dv/dio_top_sva.sv
/*
 * checker on the ports of the digital pin block.
 * assumes a single clock and async active-low reset.
 */
module dio_top_sva #(
    parameter int N_PIN = 22,
    parameter int N_TW  = 2
) (
    input wire logic               sys_clk_i,
    input wire logic               rst_b_i,
    input wire logic               ce_i,
    input wire logic               avs_read_i,
    input wire logic               avs_write_i,
    input wire logic [31:0]        avs_readdata_o,
    input wire logic               avs_waitrequest_o,
    input wire logic [N_PIN-1:0]   pin_i,
    input wire logic [N_PIN-1:0]   pin_oe_o,
    input wire logic [N_PIN-1:0]   periph_in_o,
    input wire logic [N_PIN*4-1:0] pad_cfg_o,
    input wire logic [N_TW-1:0]    tw_mode_o,
    input wire logic               pwr_sleep_i,
    input wire logic               pwr_pd_i,
    input wire logic               pwr_dpd_i,
    input wire logic               wake_sleep_o,
    input wire logic               wake_pd_o,
    input wire logic               reboot_req_o,
    input wire logic               irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] age_reg;
    logic       req;
    assign req = avs_read_i || avs_write_i;
    default clocking cb @(posedge sys_clk_i); endclocking
    ////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            age_reg <= 2'h0;
        end else if (age_reg != 2'h3) begin
            age_reg <= age_reg + 2'h1;
        end
    end
    one_wait_a: assert property (disable iff (!rst_b_i)
        $rose(req) && ce_i |-> avs_waitrequest_o ##1
        (!avs_waitrequest_o || !ce_i)) else $error("wait state wrong");
    rdata_hold_a: assert property (disable iff (!rst_b_i)
        !$past(req) |-> $stable(avs_readdata_o))
        else $error("read data moved");
    reset_quiet_a: assert property (
        !rst_b_i && !$past(rst_b_i) |-> pin_oe_o == '0 && !irq_o)
        else $error("reset state");
    sync_delay_a: assert property (disable iff (!rst_b_i)
        age_reg == 2'h3 && $past(ce_i) && $past(ce_i, 2)
        |-> periph_in_o == $past(pin_i, 2)) else $error("sync delay");
    sleep_wake_a: assert property (disable iff (!rst_b_i)
        wake_sleep_o |-> pwr_sleep_i && irq_o)
        else $error("wake outside sleep");
    pd_wake_a: assert property (disable iff (!rst_b_i)
        $rose(wake_pd_o) |-> $past(pwr_pd_i || pwr_dpd_i))
        else $error("wake outside power-down");
    reboot_pulse_a: assert property (disable iff (!rst_b_i)
        reboot_req_o && ce_i |=> !reboot_req_o)
        else $error("reboot not a pulse");
    tw_mode_a: assert property (disable iff (!rst_b_i)
        tw_mode_o == {pad_cfg_o[N_PIN*4-1], pad_cfg_o[N_PIN*4-5]})
        else $error("two-wire mode mismatch");
    tw_pull_a: assert property (disable iff (!rst_b_i)
        !pad_cfg_o[N_PIN*4-2] && !pad_cfg_o[N_PIN*4-6])
        else $error("pull-down on two-wire cell");
    irq_seen_c: cover property (disable iff (!rst_b_i) $rose(irq_o));
    pd_wake_c: cover property (disable iff (!rst_b_i) $rose(wake_pd_o));
    reboot_c: cover property (disable iff (!rst_b_i) reboot_req_o);
endmodule : dio_top_sva

bind dio_top dio_top_sva #(.N_PIN(N_PIN), .N_TW(N_TW)) u_sva (
    .sys_clk_i, .rst_b_i, .ce_i, .avs_read_i, .avs_write_i,
    .avs_readdata_o, .avs_waitrequest_o, .pin_i, .pin_oe_o,
    .periph_in_o, .pad_cfg_o, .tw_mode_o, .pwr_sleep_i, .pwr_pd_i,
    .pwr_dpd_i, .wake_sleep_o, .wake_pd_o, .reboot_req_o, .irq_o
);

//--- dv/testbench.sv
/*
 * self-checking bench for the digital pin block.
 * assumes dio_pkg, dio_top, dio_brd and the bound checker.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] M22 = 32'h003F_FFFF;
    logic        sys_clk_i, rst_b_i, ce_i, avs_read_i, avs_write_i;
    logic        avs_waitrequest_o, pwr_sleep_i, pwr_pd_i, pwr_dpd_i;
    logic        wake_sleep_o, wake_pd_o, reboot_req_o, irq_o, pol;
    logic [7:0]  avs_address_i;
    logic [3:0]  avs_byteenable_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, a, b, exp_q[$], msk_q[$];
    logic [21:0] pin_i, pin_o, pin_oe_o, periph_out_i, periph_oe_i;
    logic [21:0] periph_in_o, brd, dir, out;
    logic [87:0] pad_cfg_o;
    logic [1:0]  tw_mode_o;
    logic [7:0]  offs[6] = '{dio_pkg::OFS_DIR, dio_pkg::OFS_GSEL,
        dio_pkg::OFS_PCTL, dio_pkg::OFS_MASK, dio_pkg::OFS_WAKE, 8'h3C};
    int          errors = 0, compares = 0, seed = 11673, cyc = 0, n, p;
    ////////////////////////////////////////////////////////////
    dio_top u_dut (.sys_clk_i, .rst_b_i, .ce_i, .avs_address_i,
        .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
        .avs_readdata_o, .avs_waitrequest_o, .pin_i, .pin_o, .pin_oe_o,
        .periph_out_i, .periph_oe_i, .periph_in_o, .pad_cfg_o, .tw_mode_o,
        .pwr_sleep_i, .pwr_pd_i, .pwr_dpd_i, .wake_sleep_o, .wake_pd_o,
        .reboot_req_o, .irq_o);
    dio_brd u_brd (.lvl_i(brd), .drv_i(pin_o), .en_i(pin_oe_o),
        .pad_o(pin_i));
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic bus(input logic wr, input logic [7:0] ad,
                       input logic [31:0] d, input logic [3:0] be);
        @(posedge sys_clk_i);
        avs_address_i <= ad;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        avs_read_i <= !wr;
        avs_write_i <= wr;
        do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        bus(1'b1, ad, d, 4'hF);
    endtask : wr
    task automatic rd(input logic [7:0] ad, input logic [31:0] e,
                      input logic [31:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        bus(1'b0, ad, 32'h0, 4'hF);
    endtask : rd
    task automatic wt(input int k);
        repeat (k) @(posedge sys_clk_i);
    endtask : wt
    // read results are matched against the oldest noted expectation
    always @(posedge sys_clk_i) begin
        if (avs_read_i && avs_waitrequest_o === 1'b0) begin
            check(avs_readdata_o & msk_q.pop_front(), exp_q.pop_front());
        end
    end
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        {rst_b_i, avs_read_i, avs_write_i, pwr_sleep_i, pwr_pd_i} = '0;
        {pwr_dpd_i, avs_address_i, avs_writedata_i, brd} = '0;
        {periph_out_i, periph_oe_i} = '0;
        avs_byteenable_i = 4'hF;
        ce_i = 1'b1;
        wt(8);
        rst_b_i <= 1'b1;
        check(32'(pin_oe_o), 32'h0);
        wr(8'h3C, 32'hFFFF_FFFF);
        foreach (offs[i]) rd(offs[i], 32'h0, 32'hFFFF_FFFF);
        rd(dio_pkg::OFS_FUNC, M22, M22);
        dir = 22'($random(seed));
        out = 22'($random(seed));
        a = $random(seed);
        b = $random(seed);
        wr(dio_pkg::OFS_DIR, 32'(dir));
        wr(dio_pkg::OFS_PIN, 32'(out));
        wr(dio_pkg::OFS_SET, a);
        wr(dio_pkg::OFS_CLR, b);
        out = (out | a[21:0]) & ~b[21:0];
        a = a ^ b;
        bus(1'b1, dio_pkg::OFS_PIN, a, 4'h2);
        out[15:8] = a[15:8];
        brd <= 22'($random(seed));
        wt(4);
        check(32'(pin_oe_o), 32'(dir));
        check(32'(pin_o & dir), 32'(out & dir));
        rd(dio_pkg::OFS_SET, 32'(out), M22);
        rd(dio_pkg::OFS_PIN, 32'((out & dir) | (brd & ~dir)), M22);
        a = $random(seed);
        periph_oe_i <= 22'($random(seed));
        wr(dio_pkg::OFS_FUNC, a);
        wt(2);
        b = 32'((dir & a[21:0]) | (periph_oe_i & ~a[21:0]));
        check(32'(pin_oe_o), b);
        wt(2);
        check(32'(periph_in_o), 32'(pin_i));
        wr(dio_pkg::OFS_FUNC, M22);
        wr(dio_pkg::OFS_DIR, 32'h0);
        brd <= 22'h0;
        wr(dio_pkg::OFS_PSEL, 32'({5'd18, 5'd13, 5'd8, 5'd3}));
        wr(dio_pkg::OFS_MASK, 32'h0000_003F);
        for (int ch = 0; ch < 4; ch++) begin
            p = 3 + 5 * ch;
            pol = ch[0];
            brd[p] <= !pol;
            wr(dio_pkg::OFS_PCTL, (pol ? 32'h11 : 32'h01) << ch);
            wt(4);
            rd(dio_pkg::OFS_STAT, 32'h0, 32'h0);
            rd(dio_pkg::OFS_STAT, 32'h0, 32'h3F);
            brd[p] <= pol;
            wt(5);
            check(32'(irq_o), 32'h1);
            brd[p] <= !pol;
            wt(5);
            rd(dio_pkg::OFS_STAT, 32'h1 << ch, 32'h3F);
            rd(dio_pkg::OFS_STAT, 32'h0, 32'h3F);
            check(32'(irq_o), 32'h0);
        end
        brd <= 22'h04_0100;
        wr(dio_pkg::OFS_PCTL, 32'h0000_1A0F);
        wt(5);
        pwr_sleep_i <= 1'b1;
        rd(dio_pkg::OFS_STAT, 32'h10, 32'h10);
        wt(1);
        check(32'(wake_sleep_o), 32'h1);
        brd <= 22'h0;
        wt(5);
        rd(dio_pkg::OFS_STAT, 32'h0, 32'h0);
        rd(dio_pkg::OFS_STAT, 32'h0, 32'h10);
        check(32'(wake_sleep_o), 32'h0);
        pwr_sleep_i <= 1'b0;
        wr(dio_pkg::OFS_PCTL, 32'h0);
        wr(dio_pkg::OFS_GSEL, 32'h84);
        wr(dio_pkg::OFS_GPOL, 32'h04);
        for (int am = 0; am < 2; am++) begin
            wr(dio_pkg::OFS_GCTL, 32'(am));
            brd <= 22'h84;
            wt(5);
            rd(dio_pkg::OFS_STAT, 32'h0, 32'h0);
            rd(dio_pkg::OFS_STAT, am ? 32'h0 : 32'h20, 32'h20);
            brd <= 22'h04;
            wt(5);
            rd(dio_pkg::OFS_STAT, 32'h0, 32'h0);
            rd(dio_pkg::OFS_STAT, 32'h20, 32'h20);
        end
        wr(dio_pkg::OFS_WAKE, 32'h4);
        pwr_pd_i <= 1'b1;
        wt(2);
        brd[2] <= 1'b0;
        for (n = 0; n < 10 && wake_pd_o !== 1'b1; n++) wt(1);
        check(32'(n < 10), 32'h1);
        pwr_pd_i <= 1'b0;
        pwr_dpd_i <= 1'b1;
        wt(2);
        brd[2] <= 1'b1;
        for (n = 0; n < 10 && reboot_req_o !== 1'b1; n++) wt(1);
        check(32'(n < 10), 32'h1);
        pwr_dpd_i <= 1'b0;
        a = $random(seed);
        b = $random(seed);
        wr(dio_pkg::OFS_DIR, M22);
        wr(dio_pkg::OFS_PIN, a);
        wr(dio_pkg::OFS_PWR, 32'h1);
        pwr_pd_i <= 1'b1;
        wr(dio_pkg::OFS_PIN, b);
        wt(2);
        check(32'(pin_o), a & M22);
        pwr_pd_i <= 1'b0;
        wt(2);
        check(32'(pin_o), b & M22);
        wr(dio_pkg::OFS_PAD0, a);
        wr(dio_pkg::OFS_PAD2, b);
        wt(2);
        check(pad_cfg_o[31:0], a);
        check(32'(pad_cfg_o[87:64]), b & 32'h00BB_FFFF);
        // clock enable low freezes the synchroniser
        wr(dio_pkg::OFS_DIR, 32'h0);
        wt(3);
        b = $random(seed);
        ce_i <= 1'b0;
        brd <= b[21:0];
        wt(4);
        check(32'(periph_in_o), 32'h4);
        ce_i <= 1'b1;
        wt(3);
        check(32'(periph_in_o), b & M22);
        // second reset in mid-run
        rst_b_i <= 1'b0;
        wt(3);
        rst_b_i <= 1'b1;
        rd(dio_pkg::OFS_MASK, 32'h0, 32'h3F);
        rd(dio_pkg::OFS_PAD0, 32'h0, 32'hFFFF_FFFF);
        rd(dio_pkg::OFS_FUNC, M22, M22);
        report_and_stop();
    end
endmodule : testbench
